// File: hw/fcs_op_timer.v
// Operation timer that keeps the sequencer busy for a fixed count.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_regs.vh"
module fcs_op_timer (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       start,
  output wire       busy,
  output wire       done
);
  reg [`FCS_OP_CYCLES_W-1:0] cnt_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {`FCS_OP_CYCLES_W{1'b0}};
    end else if (start && cnt_q == {`FCS_OP_CYCLES_W{1'b0}}) begin
      cnt_q <= `FCS_OP_CYCLES;
    end else if (cnt_q != {`FCS_OP_CYCLES_W{1'b0}}) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign busy = (cnt_q != {`FCS_OP_CYCLES_W{1'b0}});
  assign done = (cnt_q == 8'h01);
endmodule // fcs_op_timer
`default_nettype wire

// File: hw/fcs_regs.vh
// Register offsets, field positions, reset values and command codes of the flash command and status unit.
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FCS_OFF_CTRL_ONE     8'h00
`define FCS_OFF_STATUS_FLAGS 8'h01
`define FCS_OFF_COMMAND      8'h02
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FCS_BIT_CMD_MODE_EN  0
`define FCS_BIT_PROGRAM      4
`define FCS_BIT_ERASE        5
`define FCS_BIT_READY        7
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FCS_RST_CTRL_ONE     8'h00
`define FCS_RST_STATUS       8'h80
// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define FCS_CMD_READ_ARRAY   8'hff
`define FCS_CMD_READ_STATUS  8'h70
`define FCS_CMD_CLEAR_STATUS 8'h50
`define FCS_CMD_PROGRAM      8'h40
`define FCS_CMD_BLOCK_ERASE  8'h20
`define FCS_CMD_BLANK_CHECK  8'h25
// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define FCS_OP_CYCLES_W      8
`define FCS_OP_CYCLES        8'h10
`endif

// File: hw/fcs_unit.v
// Flash command mode entry and status reporting unit.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_regs.vh"
module fcs_unit (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       flash_rd,
  input  wire       flash_addr_lsb,
  input  wire [7:0] array_rdata,
  output reg  [7:0] flash_rdata,
  input  wire       op_fail_program,
  input  wire       op_fail_erase,
  output wire       user_command_mode
);
  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_i_n = rst_s2_q;

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  reg        command_mode_enable_q;
  reg        program_error_flag_q;
  reg        erase_error_flag_q;
  reg        op_is_erase_q;
  wire       op_busy;
  wire       op_done;
  wire       ctrl_wr;
  wire       cmd_wr;
  wire       cmd_read_array;
  wire       cmd_read_status;
  wire       cmd_clear_status;
  wire       cmd_program;
  wire       cmd_block_erase;
  wire       cmd_blank_check;
  wire       is_op;
  wire       any_err;
  wire       op_start;

  // Command writes count only once command mode is on, so a stray write before entry cannot start anything.
  assign ctrl_wr          = reg_wr && (reg_addr == `FCS_OFF_CTRL_ONE);
  assign cmd_wr           = reg_wr && (reg_addr == `FCS_OFF_COMMAND) && command_mode_enable_q;
  assign cmd_read_array   = cmd_wr && (reg_wdata == `FCS_CMD_READ_ARRAY);
  assign cmd_read_status  = cmd_wr && (reg_wdata == `FCS_CMD_READ_STATUS);
  assign cmd_clear_status = cmd_wr && (reg_wdata == `FCS_CMD_CLEAR_STATUS);
  assign cmd_program      = cmd_wr && (reg_wdata == `FCS_CMD_PROGRAM);
  assign cmd_block_erase  = cmd_wr && (reg_wdata == `FCS_CMD_BLOCK_ERASE);
  assign cmd_blank_check  = cmd_wr && (reg_wdata == `FCS_CMD_BLANK_CHECK);
  assign is_op            = cmd_program || cmd_block_erase || cmd_blank_check;
  assign any_err          = program_error_flag_q || erase_error_flag_q;
  // A running operation also refuses a new one, because the timer cannot restart mid-count.
  assign op_start         = is_op && !any_err && !op_busy;

  // --------------------------------------------------------------------------
  // Command mode entry
  // --------------------------------------------------------------------------
  assign user_command_mode = command_mode_enable_q;

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      command_mode_enable_q <= 1'b0;
    end else if (ctrl_wr) begin
      command_mode_enable_q <= reg_wdata[`FCS_BIT_CMD_MODE_EN];
    end
  end

  // --------------------------------------------------------------------------
  // Operation timer
  // --------------------------------------------------------------------------
  fcs_op_timer u_timer (
    .clk   (clk),
    .rst_n (rst_i_n),
    .start (op_start),
    .busy  (op_busy),
    .done  (op_done)
  );

  // The kind of operation is kept so that only the matching failure input can raise an error at its end.
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      op_is_erase_q <= 1'b0;
    end else if (op_start) begin
      op_is_erase_q <= cmd_block_erase;
    end
  end

  // --------------------------------------------------------------------------
  // Error flags
  // --------------------------------------------------------------------------
  // A failure reported at operation end wins over a clear in the same cycle, so no error is lost.
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      program_error_flag_q <= 1'b0;
    end else if (op_done && op_fail_program && !op_is_erase_q) begin
      program_error_flag_q <= 1'b1;
    end else if (cmd_clear_status) begin
      program_error_flag_q <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      erase_error_flag_q <= 1'b0;
    end else if (op_done && op_fail_erase && op_is_erase_q) begin
      erase_error_flag_q <= 1'b1;
    end else if (cmd_clear_status) begin
      erase_error_flag_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Read mode
  // --------------------------------------------------------------------------
  // The mode survives leaving command mode; it is only acted on while command mode is on.
  localparam [0:0] RD_ARRAY  = 1'b0;
  localparam [0:0] RD_STATUS = 1'b1;

  reg  [0:0] rd_mode_q;
  reg  [0:0] rd_mode_d;

  always @* begin
    rd_mode_d = rd_mode_q;
    case (rd_mode_q)
      RD_ARRAY: begin
        if (cmd_read_status || is_op) begin
          rd_mode_d = RD_STATUS;
        end
      end
      RD_STATUS: begin
        if (cmd_read_array) begin
          rd_mode_d = RD_ARRAY;
        end
      end
      default: begin
        rd_mode_d = RD_ARRAY;
      end
    endcase
  end

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rd_mode_q <= RD_ARRAY;
    end else begin
      rd_mode_q <= rd_mode_d;
    end
  end

  // --------------------------------------------------------------------------
  // Status byte
  // --------------------------------------------------------------------------
  // Each bit is placed by its field position; bits without a status meaning stay 0.
  wire [7:0] status_byte;
  genvar     gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_status_bit
      if (gi == `FCS_BIT_READY) begin : g_ready
        assign status_byte[gi] = !op_busy;
      end else if (gi == `FCS_BIT_ERASE) begin : g_erase
        assign status_byte[gi] = erase_error_flag_q;
      end else if (gi == `FCS_BIT_PROGRAM) begin : g_program
        assign status_byte[gi] = program_error_flag_q;
      end else begin : g_reserved
        assign status_byte[gi] = 1'b0;
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Register read path
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FCS_OFF_CTRL_ONE: begin
          reg_rdata <= {7'h00, command_mode_enable_q};
        end
        `FCS_OFF_STATUS_FLAGS: begin
          reg_rdata <= status_byte;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Flash read path
  // --------------------------------------------------------------------------
  // Status replaces array data on even bytes only, so odd bytes of a word read still come from the array.
  wire       status_on_bus = command_mode_enable_q && (rd_mode_q == RD_STATUS) && !flash_addr_lsb;

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      flash_rdata <= 8'h00;
    end else if (flash_rd) begin
      if (status_on_bus) begin
        flash_rdata <= status_byte;
      end else begin
        flash_rdata <= array_rdata;
      end
    end
  end
endmodule // fcs_unit
`default_nettype wire

// File: verif/fcs_flash_model.sv
// Flash array model that feeds read data to the unit.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model (
  input  wire logic       clk,
  output var  logic [7:0] array_rdata
);
  // The word moves every cycle so a stale copy never passes for a fresh read.
  initial array_rdata = 8'h3c;
  always @(posedge clk) array_rdata <= array_rdata + 8'h1d;
endmodule // fcs_flash_model
`default_nettype wire

// File: verif/fcs_unit_monitor.sv
// Assertion checker for the flash command and status unit.
`timescale 1ns/1ps
`default_nettype none
module fcs_unit_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       flash_rd,
  input wire logic       flash_addr_lsb,
  input wire logic [7:0] array_rdata,
  input wire logic [7:0] flash_rdata,
  input wire logic       op_fail_program,
  input wire logic       op_fail_erase,
  input wire logic       user_command_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A failing operation may set an error bit late, so the clear check waits for quiet inputs.
  wire q = !op_fail_program && !op_fail_erase;
  sequence s_clr; q && user_command_mode && reg_wr && reg_addr == 8'h02 && reg_wdata == 8'h50; endsequence
  sequence s_srd; reg_rd && reg_addr == 8'h01; endsequence
  property p_mode; reg_wr && reg_addr == 8'h00 |=> user_command_mode == $past(reg_wdata[0]); endproperty
  a_mode: assert property (p_mode) else $error("mode bit");
  property p_mhold; !(reg_wr && reg_addr == 8'h00) |=> $stable(user_command_mode); endproperty
  a_mhold: assert property (p_mhold) else $error("mode drift");
  property p_clr; s_clr ##1 q ##1 (s_srd and q) |=> reg_rdata[5:4] == 2'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_rsv; s_srd |=> (reg_rdata & 8'h4f) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_odd; flash_rd && flash_addr_lsb |=> flash_rdata == $past(array_rdata); endproperty
  a_odd: assert property (p_odd) else $error("odd read");
  property p_unm; reg_rd && reg_addr > 8'h02 |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata hold");
  property p_fhold; !flash_rd |=> $stable(flash_rdata); endproperty
  a_fhold: assert property (p_fhold) else $error("flash hold");
endmodule // fcs_unit_monitor
bind fcs_unit fcs_unit_monitor mon_u (
  .clk               (clk),
  .rst_n             (rst_n),
  .reg_wr            (reg_wr),
  .reg_rd            (reg_rd),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_rdata         (reg_rdata),
  .flash_rd          (flash_rd),
  .flash_addr_lsb    (flash_addr_lsb),
  .array_rdata       (array_rdata),
  .flash_rdata       (flash_rdata),
  .op_fail_program   (op_fail_program),
  .op_fail_erase     (op_fail_erase),
  .user_command_mode (user_command_mode)
);
`default_nettype wire

// File: verif/test_flash_command_status_unit.sv
// Self-checking bench for the flash command and status unit.
`timescale 1ns/1ps
`default_nettype none
module test_flash_command_status_unit;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, frd = 0, lsb = 0, fp = 0, fe = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, cmd [3] = '{8'h40, 8'h20, 8'h25}, st [3] = '{8'h90, 8'ha0, 8'h90};
  wire [7:0] rdata, frdata, arr;
  wire mode;
  int fail_count = 0, n_tests = 0;
  always #2 clk = ~clk;
  fcs_flash_model fm_u (.clk(clk), .array_rdata(arr));
  fcs_unit dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdata), .flash_rd(frd), .flash_addr_lsb(lsb), .array_rdata(arr), .flash_rdata(frdata),
    .op_fail_program(fp), .op_fail_erase(fe), .user_command_mode(mode));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {wr_s, addr, wd} = {1'b1, a, d};
    @(negedge clk) wr_s = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) {rd_s, addr} = {1'b1, a};
    @(negedge clk) rd_s = 0;
    chk(rdata, exp);
  endtask
  // With use_arr set the expected byte is the array word sampled at the read edge.
  task fr(input logic l, input logic [7:0] exp, input logic use_arr);
    logic [7:0] e;
    @(negedge clk) {frd, lsb} = {1'b1, l};
    e = use_arr ? arr : exp;
    @(negedge clk) frd = 0;
    chk(frdata, e);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    rd(8'h01, 8'h80);
    wr(8'h02, 8'h40);
    rd(8'h01, 8'h80);
    wr(8'h00, 8'h01);
    chk({7'h00, mode}, 8'h01);
    wr(8'h02, 8'h70);
    fr(1'b0, 8'h80, 1'b0);
    fr(1'b1, 8'h00, 1'b1);
    $display("entry test done");
    for (int i = 0; i < 3; i++) begin
      {fp, fe} = 2'b11;
      wr(8'h02, cmd[i]);
      rd(8'h01, 8'h00);
      repeat (20) @(negedge clk);
      rd(8'h01, st[i]);
      fr(1'b0, st[i], 1'b0);
      wr(8'h02, 8'h20);
      rd(8'h01, st[i]);
      wr(8'h02, 8'hff);
      fr(1'b0, 8'h00, 1'b1);
      {fp, fe} = 2'b00;
      wr(8'h02, 8'h50);
      rd(8'h01, 8'h80);
      $display("command test %0d done", i);
    end
    {fp, fe} = 2'b00;
    wr(8'h02, 8'h40);
    repeat (20) @(negedge clk);
    rd(8'h01, 8'h80);
    fr(1'b0, 8'h80, 1'b0);
    rd(8'h05, 8'h00);
    rd(8'h00, 8'h01);
    $display("op success test done");
    rst_n = 0;
    repeat (2) @(negedge clk);
    chk(rdata, 8'h00);
    chk(frdata, 8'h00);
    rst_n = 1;
    repeat (3) @(negedge clk);
    rd(8'h01, 8'h80);
    chk({7'h00, mode}, 8'h00);
    $display("reset test done");
    wrap_up;
  end
  initial begin
    #20000;
    fail_count++;
    wrap_up;
  end
endmodule // test_flash_command_status_unit
`default_nettype wire
